/* core/alrb_defs.svh */
// Purpose: offsets, field positions and timing counts of the register bridge
// Assumes: included by bare name from the design files
// Notes: word offsets are in 32-bit units
`ifndef ALRB_DEFS_SVH
`define ALRB_DEFS_SVH

`define ALRB_WORD_ADDR_W 11
`define ALRB_AREA_LSB 9
`define ALRB_AREA_MSB 10
`define ALRB_AREA_TOE 2'h0
`define ALRB_AREA_MAC 2'h1
`define ALRB_AREA_GEN 2'h2
`define ALRB_AREA_VER 2'h3
`define ALRB_AREA_TOE_BASE 11'h000
`define ALRB_AREA_MAC_BASE 11'h200
`define ALRB_AREA_GEN_BASE 11'h400
`define ALRB_AREA_VER_BASE 11'h600
`define ALRB_CTRL_IDX 9'h000
`define ALRB_LEN_IDX 9'h001
`define ALRB_COUNT_IDX 9'h002
`define ALRB_STAT_IDX 9'h003
`define ALRB_ENABLE_BIT 0
`define ALRB_BYTE_LANES 4
`define ALRB_RD_LATENCY 2
`define ALRB_RESP_OKAY 2'h0
`define ALRB_RESET_WORD 32'h0000_0000

`endif

/* core/alrb_pkg.sv */
// Purpose: shared types of the register bridge
// Assumes: nothing
// Notes: state codes are one-hot
package alrb_pkg;

  typedef enum logic [5:0] {
    ALRB_IDLE    = 6'b000001,
    ALRB_WR_XFER = 6'b000010,
    ALRB_WR_RESP = 6'b000100,
    ALRB_RD_WAIT = 6'b001000,
    ALRB_RD_XFER = 6'b010000,
    ALRB_RD_RESP = 6'b100000
  } alrb_bridge_state_t;

  typedef logic [31:0] alrb_word_t;

endpackage

/* core/alrb_pattern_verifier.sv */
// Purpose: checks an incrementing 32-bit word stream
// Assumes: stream source sends 0,1,2,... after each enable
// Notes: control and status cross through two-flop stages
`timescale 1ns/1ps
`include "alrb_defs.svh"

module alrb_pattern_verifier
  import alrb_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic enable_in,
  input wire logic [31:0] rx_tdata_in,
  input wire logic rx_tvalid_in,
  output logic rx_tready_out,
  output logic fail_out,
  output logic [31:0] count_out
);

  logic en_meta_q, en_sync_q, en_d1_q;
  logic [31:0] expect_q, expect_d;
  logic fail_q, fail_d;
  logic [31:0] cnt_s1_q;
  logic fail_s1b_q;

  always_comb begin
    expect_d = expect_q;
    fail_d = fail_q;
    if (en_sync_q && !en_d1_q) begin
      expect_d = `ALRB_RESET_WORD;
      fail_d = 1'b0;
    end else if (rx_tready_out && rx_tvalid_in) begin
      expect_d = expect_q + 32'h0000_0001;
      if (rx_tdata_in != expect_q) begin
        fail_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      en_meta_q <= 1'b0;
      en_sync_q <= 1'b0;
      en_d1_q <= 1'b0;
      expect_q <= `ALRB_RESET_WORD;
      fail_q <= 1'b0;
      fail_s1b_q <= 1'b0;
      cnt_s1_q <= `ALRB_RESET_WORD;
      fail_out <= 1'b0;
      count_out <= `ALRB_RESET_WORD;
      rx_tready_out <= 1'b0;
    end else begin
      en_meta_q <= enable_in;
      en_sync_q <= en_meta_q;
      en_d1_q <= en_sync_q;
      expect_q <= expect_d;
      fail_q <= fail_d;
      fail_s1b_q <= fail_q;
      cnt_s1_q <= expect_q;
      fail_out <= fail_s1b_q;
      count_out <= cnt_s1_q;
      rx_tready_out <= en_sync_q;
    end
  end

endmodule

/* core/alrb_bus_to_register_top.sv */
// Purpose: bus slave to register bridge with register block and test streams
// Assumes: one clock; bus master keeps to the 32-bit lite protocol
// Notes: one transaction at a time on the register side
`timescale 1ns/1ps
`include "alrb_defs.svh"

module alrb_bus_to_register_top
  import alrb_pkg::*;
#(
  parameter int ADDR_W = 13,
  parameter int LOCAL_WORDS = 16
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] tx_tdata_out,
  output logic tx_tvalid_out,
  input wire logic tx_tready_in,
  input wire logic [31:0] rx_tdata_in,
  input wire logic rx_tvalid_in,
  output logic rx_tready_out
);

  localparam int WA = `ALRB_WORD_ADDR_W;

  // word index slices below need a power of two
  if (ADDR_W < WA + 2) begin : g_bad_addr_w
    $error("ADDR_W too small for the register space");
  end
  if (LOCAL_WORDS < 4 || LOCAL_WORDS > 512 || (LOCAL_WORDS & (LOCAL_WORDS - 1)) != 0) begin : g_bad_words
    $error("LOCAL_WORDS must be a power of two from 4 to 512");
  end

  function automatic logic [1:0] area_of(input logic [WA-1:0] a);
    area_of = a[`ALRB_AREA_MSB:`ALRB_AREA_LSB];
  endfunction

  function automatic logic [8:0] index_of(input logic [WA-1:0] a);
    index_of = a[`ALRB_AREA_LSB-1:0];
  endfunction

  // bridge state
  alrb_bridge_state_t state_q, state_d;
  logic aw_full_q, aw_full_d, w_full_q, w_full_d, ar_full_q, ar_full_d;
  logic [WA-1:0] aw_addr_q, aw_addr_d, ar_addr_q, ar_addr_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_lanes_q, w_lanes_d;
  logic [WA-1:0] x_addr_q, x_addr_d;
  logic [31:0] x_wvalue_q, x_wvalue_d, x_rvalue_q, x_rvalue_d;
  logic [3:0] x_lanes_q, x_lanes_d;
  logic [WA-1:0] reg_word_addr_q, reg_word_addr_d;
  logic reg_write_strobe_q, reg_write_strobe_d;
  logic [31:0] reg_write_value_q, reg_write_value_d;
  logic [3:0] reg_byte_lanes_q, reg_byte_lanes_d;
  logic reg_read_request_q, reg_read_request_d;
  logic awready_d, wready_d, arready_d, bvalid_d, rvalid_d;
  logic [31:0] rdata_d;

  // register side
  logic [31:0] store_q [4][LOCAL_WORDS];
  logic [31:0] store_d [4][LOCAL_WORDS];
  logic rd_stage1_q, register_read_valid_q;
  logic [31:0] sub_word_q [4];
  logic [31:0] sub_word_d [4];
  logic [31:0] register_read_value_q, register_read_value_d;

  // pattern generator and verifier outputs
  logic [31:0] gen_data_q, gen_data_d, gen_sent_q, gen_sent_d;
  logic gen_tvalid_d;
  logic ver_fail;
  logic [31:0] ver_count;

  always_comb begin
    state_d = state_q;
    aw_full_d = aw_full_q;
    w_full_d = w_full_q;
    ar_full_d = ar_full_q;
    aw_addr_d = aw_addr_q;
    ar_addr_d = ar_addr_q;
    w_data_d = w_data_q;
    w_lanes_d = w_lanes_q;
    x_addr_d = x_addr_q;
    x_wvalue_d = x_wvalue_q;
    x_lanes_d = x_lanes_q;
    x_rvalue_d = x_rvalue_q;
    reg_word_addr_d = reg_word_addr_q;
    reg_write_value_d = reg_write_value_q;
    reg_byte_lanes_d = reg_byte_lanes_q;
    reg_write_strobe_d = 1'b0;
    reg_read_request_d = 1'b0;
    bvalid_d = s_axi_bvalid_out;
    rvalid_d = s_axi_rvalid_out;
    rdata_d = s_axi_rdata_out;
    // each handshake captured on its own, one deep per channel
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_full_d = 1'b1;
      aw_addr_d = s_axi_awaddr_in[WA+1:2];
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_full_d = 1'b1;
      w_data_d = s_axi_wdata_in;
      w_lanes_d = s_axi_wstrb_in;
    end
    if (s_axi_arvalid_in && s_axi_arready_out) begin
      ar_full_d = 1'b1;
      ar_addr_d = s_axi_araddr_in[WA+1:2];
    end
    unique case (state_q)
      ALRB_IDLE: begin
        // writes first; the shared address allows only one access at a time
        if (aw_full_q && w_full_q) begin
          x_addr_d = aw_addr_q;
          x_wvalue_d = w_data_q;
          x_lanes_d = w_lanes_q;
          aw_full_d = 1'b0;
          w_full_d = 1'b0;
          state_d = ALRB_WR_XFER;
        end else if (ar_full_q) begin
          reg_word_addr_d = ar_addr_q;
          reg_read_request_d = 1'b1;
          ar_full_d = 1'b0;
          state_d = ALRB_RD_WAIT;
        end
      end
      ALRB_WR_XFER: begin
        reg_word_addr_d = x_addr_q;
        reg_write_value_d = x_wvalue_q;
        reg_byte_lanes_d = x_lanes_q;
        reg_write_strobe_d = 1'b1;
        state_d = ALRB_WR_RESP;
      end
      ALRB_WR_RESP: begin
        if (!s_axi_bvalid_out) begin
          bvalid_d = 1'b1;
        end else if (s_axi_bready_in) begin
          bvalid_d = 1'b0;
          state_d = ALRB_IDLE;
        end
      end
      ALRB_RD_WAIT: begin
        // address left alone here so the read muxes stay steered
        if (register_read_valid_q) begin
          x_rvalue_d = register_read_value_q;
          state_d = ALRB_RD_XFER;
        end
      end
      ALRB_RD_XFER: begin
        rdata_d = x_rvalue_q;
        rvalid_d = 1'b1;
        state_d = ALRB_RD_RESP;
      end
      ALRB_RD_RESP: begin
        if (s_axi_rready_in) begin
          rvalid_d = 1'b0;
          state_d = ALRB_IDLE;
        end
      end
      default: begin
        state_d = ALRB_IDLE;
      end
    endcase
    // readies stay low until the answer so only one access per direction is open
    awready_d = !aw_full_d && !(state_d inside {ALRB_WR_XFER, ALRB_WR_RESP});
    wready_d = !w_full_d && !(state_d inside {ALRB_WR_XFER, ALRB_WR_RESP});
    arready_d = !ar_full_d && !(state_d inside {ALRB_RD_WAIT, ALRB_RD_XFER, ALRB_RD_RESP});
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state_q <= ALRB_IDLE;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      ar_full_q <= 1'b0;
      aw_addr_q <= '0;
      ar_addr_q <= '0;
      w_data_q <= `ALRB_RESET_WORD;
      w_lanes_q <= 4'h0;
      x_addr_q <= '0;
      x_wvalue_q <= `ALRB_RESET_WORD;
      x_lanes_q <= 4'h0;
      x_rvalue_q <= `ALRB_RESET_WORD;
      reg_word_addr_q <= '0;
      reg_write_value_q <= `ALRB_RESET_WORD;
      reg_byte_lanes_q <= 4'h0;
      reg_write_strobe_q <= 1'b0;
      reg_read_request_q <= 1'b0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
      s_axi_arready_out <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= `ALRB_RESET_WORD;
      s_axi_bresp_out <= `ALRB_RESP_OKAY;
      s_axi_rresp_out <= `ALRB_RESP_OKAY;
    end else begin
      state_q <= state_d;
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      ar_full_q <= ar_full_d;
      aw_addr_q <= aw_addr_d;
      ar_addr_q <= ar_addr_d;
      w_data_q <= w_data_d;
      w_lanes_q <= w_lanes_d;
      x_addr_q <= x_addr_d;
      x_wvalue_q <= x_wvalue_d;
      x_lanes_q <= x_lanes_d;
      x_rvalue_q <= x_rvalue_d;
      reg_word_addr_q <= reg_word_addr_d;
      reg_write_value_q <= reg_write_value_d;
      reg_byte_lanes_q <= reg_byte_lanes_d;
      reg_write_strobe_q <= reg_write_strobe_d;
      reg_read_request_q <= reg_read_request_d;
      s_axi_awready_out <= awready_d;
      s_axi_wready_out <= wready_d;
      s_axi_arready_out <= arready_d;
      s_axi_bvalid_out <= bvalid_d;
      s_axi_rvalid_out <= rvalid_d;
      s_axi_rdata_out <= rdata_d;
      s_axi_bresp_out <= `ALRB_RESP_OKAY;
      s_axi_rresp_out <= `ALRB_RESP_OKAY;
    end
  end

  // register block: whole-word storage, lanes kept only for the interface
  always_comb begin
    logic [1:0] wa;
    logic [8:0] wi;
    logic [1:0] ra;
    logic [8:0] ri;
    wa = area_of(reg_word_addr_q);
    wi = index_of(reg_word_addr_q);
    ra = area_of(reg_word_addr_q);
    ri = index_of(reg_word_addr_q);
    store_d = store_q;
    if (reg_write_strobe_q && {1'b0, wi} < 10'(LOCAL_WORDS)) begin
      store_d[wa][wi[$clog2(LOCAL_WORDS)-1:0]] = reg_write_value_q;
    end
    for (int a = 0; a < 4; a++) begin
      sub_word_d[a] = `ALRB_RESET_WORD;
      if ({1'b0, ri} < 10'(LOCAL_WORDS)) begin
        sub_word_d[a] = store_q[a][ri[$clog2(LOCAL_WORDS)-1:0]];
      end
    end
    // status words are read-only views of the stream logic
    if (ri == `ALRB_COUNT_IDX) begin
      sub_word_d[`ALRB_AREA_GEN] = gen_sent_q;
      sub_word_d[`ALRB_AREA_VER] = ver_count;
    end
    if (ri == `ALRB_STAT_IDX) begin
      sub_word_d[`ALRB_AREA_GEN] = {31'h0, tx_tvalid_out};
      sub_word_d[`ALRB_AREA_VER] = {31'h0, ver_fail};
    end
    register_read_value_d = sub_word_q[ra];
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      for (int a = 0; a < 4; a++) begin
        for (int i = 0; i < LOCAL_WORDS; i++) begin
          store_q[a][i] <= `ALRB_RESET_WORD;
        end
        sub_word_q[a] <= `ALRB_RESET_WORD;
      end
      rd_stage1_q <= 1'b0;
      register_read_valid_q <= 1'b0;
      register_read_value_q <= `ALRB_RESET_WORD;
    end else begin
      store_q <= store_d;
      sub_word_q <= sub_word_d;
      rd_stage1_q <= reg_read_request_q;
      register_read_valid_q <= rd_stage1_q;
      register_read_value_q <= register_read_value_d;
    end
  end

  // pattern generator: restarts on each write to its control word
  always_comb begin
    logic restart;
    restart = reg_write_strobe_q && area_of(reg_word_addr_q) == `ALRB_AREA_GEN
      && index_of(reg_word_addr_q) == `ALRB_CTRL_IDX;
    gen_data_d = gen_data_q;
    gen_sent_d = gen_sent_q;
    if (restart) begin
      gen_data_d = `ALRB_RESET_WORD;
      gen_sent_d = `ALRB_RESET_WORD;
    end else if (tx_tvalid_out && tx_tready_in) begin
      gen_data_d = gen_data_q + 32'h0000_0001;
      gen_sent_d = gen_sent_q + 32'h0000_0001;
    end
    gen_tvalid_d = !restart && store_q[`ALRB_AREA_GEN][0][`ALRB_ENABLE_BIT]
      && gen_sent_d < store_q[`ALRB_AREA_GEN][1];
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      gen_data_q <= `ALRB_RESET_WORD;
      gen_sent_q <= `ALRB_RESET_WORD;
      tx_tdata_out <= `ALRB_RESET_WORD;
      tx_tvalid_out <= 1'b0;
    end else begin
      gen_data_q <= gen_data_d;
      gen_sent_q <= gen_sent_d;
      tx_tdata_out <= gen_data_d;
      tx_tvalid_out <= gen_tvalid_d;
    end
  end

  alrb_pattern_verifier u_verifier (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .enable_in(store_q[`ALRB_AREA_VER][0][`ALRB_ENABLE_BIT]),
    .rx_tdata_in(rx_tdata_in),
    .rx_tvalid_in(rx_tvalid_in),
    .rx_tready_out(rx_tready_out),
    .fail_out(ver_fail),
    .count_out(ver_count)
  );

endmodule

/* tb/alrb_bridge_chk.sv */
// Purpose: port assertions of the register bridge
// Assumes: master never offers aw and ar at one edge
// Notes: latencies counted through the bridge pipeline stages
`timescale 1ns/1ps
module alrb_bridge_chk (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [31:0] tx_tdata_out,
  input wire logic tx_tvalid_out,
  input wire logic tx_tready_in
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  wire aw_hs = s_axi_awvalid_in && s_axi_awready_out;
  wire w_hs = s_axi_wvalid_in && s_axi_wready_out;
  wire ar_hs = s_axi_arvalid_in && s_axi_arready_out;
  property p_bresp;
    s_axi_bvalid_out |-> s_axi_bresp_out == 2'h0;
  endproperty
  a_bresp: assert property (p_bresp) else $error("write answer not okay");
  property p_b_hold;
    s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
  property p_b_done;
    s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write answer repeated");
  property p_aw_once;
    aw_hs |=> !s_axi_awready_out;
  endproperty
  a_aw_once: assert property (p_aw_once) else $error("second write address taken");
  property p_wr_ans;
    aw_hs && w_hs |-> ##[3:4] s_axi_bvalid_out;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_ar_once;
    ar_hs |=> !s_axi_arready_out;
  endproperty
  a_ar_once: assert property (p_ar_once) else $error("second read address taken");
  property p_rd_lat;
    ar_hs && !aw_hs |-> !s_axi_rvalid_out [*6] ##1 s_axi_rvalid_out;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer timing wrong");
  property p_r_hold;
    s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  property p_tx_hold;
    tx_tvalid_out && !tx_tready_in |=> tx_tvalid_out && $stable(tx_tdata_out);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("stream word not held");
endmodule

bind alrb_bus_to_register_top alrb_bridge_chk alrb_bridge_chk_inst (.clock_in, .rst_n_in,
  .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
  .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
  .s_axi_rvalid_out, .s_axi_rready_in, .tx_tdata_out, .tx_tvalid_out, .tx_tready_in);

/* tb/alrb_cpu_model.sv */
// Purpose: processor-side lite bus master
// Assumes: one request per direction at a time
// Notes: released address and data lines show inverted values so stale data is never seen; wstrb keeps its value
`timescale 1ns/1ps
module alrb_cpu_model
  import alrb_pkg::*;
(
  input wire logic clock_in,
  output logic [12:0] awaddr_out = 13'h0,
  output logic awvalid_out = 1'b0,
  input wire logic awready_in,
  output alrb_word_t wdata_out = 32'h0,
  output logic [3:0] wstrb_out = 4'h0,
  output logic wvalid_out = 1'b0,
  input wire logic wready_in,
  input wire logic [1:0] bresp_in,
  input wire logic bvalid_in,
  output logic bready_out = 1'b0,
  output logic [12:0] araddr_out = 13'h0,
  output logic arvalid_out = 1'b0,
  input wire logic arready_in,
  input wire alrb_word_t rdata_in,
  input wire logic rvalid_in,
  output logic rready_out = 1'b0
);
  task automatic write_word(input logic [12:0] a, input alrb_word_t d, input logic [3:0] s, input int stall,
                            output logic [1:0] resp, output bit ok);
    int n;
    bit aw_ok;
    bit w_ok;
    n = 0;
    aw_ok = 0;
    w_ok = 0;
    @(posedge clock_in);
    awaddr_out <= a;
    awvalid_out <= 1'b1;
    wdata_out <= d;
    wstrb_out <= s;
    wvalid_out <= 1'b1;
    while (!(aw_ok && w_ok) && n < 40) begin
      @(posedge clock_in);
      n++;
      if (!aw_ok && awready_in) begin
        aw_ok = 1;
        awvalid_out <= 1'b0;
        awaddr_out <= ~a;
      end
      if (!w_ok && wready_in) begin
        w_ok = 1;
        wvalid_out <= 1'b0;
        wdata_out <= ~d;
      end
    end
    while (!bvalid_in && n < 40) begin
      @(posedge clock_in);
      n++;
    end
    repeat (stall) @(posedge clock_in);
    bready_out <= 1'b1;
    @(posedge clock_in);
    resp = bresp_in;
    bready_out <= 1'b0;
    ok = (n < 40);
  endtask
  task automatic read_word(input logic [12:0] a, input int stall, output alrb_word_t d, output bit ok);
    int n;
    n = 0;
    @(posedge clock_in);
    araddr_out <= a;
    arvalid_out <= 1'b1;
    do begin
      @(posedge clock_in);
      n++;
    end while (!arready_in && n < 40);
    arvalid_out <= 1'b0;
    araddr_out <= ~a;
    while (!rvalid_in && n < 40) begin
      @(posedge clock_in);
      n++;
    end
    repeat (stall) @(posedge clock_in);
    rready_out <= 1'b1;
    @(posedge clock_in);
    d = rdata_in;
    rready_out <= 1'b0;
    ok = (n < 40);
  endtask
endmodule

/* tb/tb_alrb_bus_to_register_top.sv */
// Purpose: self-checking bench of the register bridge
// Assumes: stream sink stalls every other pair of cycles
// Notes: verifier status is read well after its sync stages settle
`timescale 1ns/1ps
`include "alrb_defs.svh"
module tb_alrb_bus_to_register_top
  import alrb_pkg::*;
;
  localparam int LW = 16;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [12:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out, s_axi_bvalid_out;
  logic s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out, s_axi_rready_in;
  logic [3:0] s_axi_wstrb_in;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, cyc_q = 2'h0;
  alrb_word_t s_axi_wdata_in, s_axi_rdata_out, tx_tdata_out, rx_tdata_in = 32'h0;
  logic tx_tvalid_out, tx_tready_in = 1'b0, rx_tvalid_in = 1'b0, rx_tready_out;
  alrb_word_t txq[$];
  int mismatches = 0;
  int n_tests = 0;
  always #12.5 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cyc_q <= cyc_q + 2'h1;
    tx_tready_in <= cyc_q[1];
    if (tx_tvalid_out && tx_tready_in) txq.push_back(tx_tdata_out);
  end
  alrb_bus_to_register_top #(.ADDR_W(13), .LOCAL_WORDS(LW)) alrb_bus_to_register_top_inst (.clock_in, .rst_n_in,
    .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in,
    .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in,
    .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .tx_tdata_out,
    .tx_tvalid_out, .tx_tready_in, .rx_tdata_in, .rx_tvalid_in, .rx_tready_out);
  alrb_cpu_model alrb_cpu_model_inst (.clock_in, .awaddr_out(s_axi_awaddr_in), .awvalid_out(s_axi_awvalid_in),
    .awready_in(s_axi_awready_out), .wdata_out(s_axi_wdata_in), .wstrb_out(s_axi_wstrb_in),
    .wvalid_out(s_axi_wvalid_in), .wready_in(s_axi_wready_out), .bresp_in(s_axi_bresp_out),
    .bvalid_in(s_axi_bvalid_out), .bready_out(s_axi_bready_in), .araddr_out(s_axi_araddr_in),
    .arvalid_out(s_axi_arvalid_in), .arready_in(s_axi_arready_out), .rdata_in(s_axi_rdata_out),
    .rvalid_in(s_axi_rvalid_out), .rready_out(s_axi_rready_in));
  function automatic logic [12:0] ba(input logic [10:0] w);
    return {w, 2'b00};
  endfunction
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic hang();
    mismatches++;
    $display("MISMATCH %0t bounded wait ran out", $time);
    tally_and_finish();
  endtask
  task automatic expect_word(input alrb_word_t got, input alrb_word_t exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus_wr(input logic [12:0] a, input alrb_word_t d, input logic [3:0] s, input int stall);
    logic [1:0] resp;
    bit ok;
    alrb_cpu_model_inst.write_word(a, d, s, stall, resp, ok);
    if (!ok) hang();
    expect_word({30'h0, resp}, 32'h0);
  endtask
  task automatic bus_rd(input logic [12:0] a, input int stall, output alrb_word_t d);
    bit ok;
    alrb_cpu_model_inst.read_word(a, stall, d, ok);
    if (!ok) hang();
    expect_word({30'h0, s_axi_rresp_out}, 32'h0);
  endtask
  task automatic rx_beat(input alrb_word_t w);
    int n;
    n = 0;
    rx_tdata_in <= w;
    rx_tvalid_in <= 1'b1;
    do begin
      @(posedge clock_in);
      n++;
    end while (!rx_tready_out && n < 40);
    if (n >= 40) hang();
  endtask
  // single-lane strobes still store whole words; write then read back to back
  task automatic t_area_map();
    alrb_word_t got;
    for (int i = 0; i < 4; i++) begin
      bus_wr(ba(11'(i * 512 + 1)), 32'hc3a5_0f00 + 32'(i), 4'h1 << i, i);
      bus_rd(ba(11'(i * 512 + 1)), 3 - i, got);
      expect_word(got, 32'hc3a5_0f00 + 32'(i));
    end
    for (int i = 0; i < 4; i++) begin
      bus_rd(ba(11'(i * 512 + 1)), 0, got);
      expect_word(got, 32'hc3a5_0f00 + 32'(i));
    end
    bus_rd(ba(11'(LW)), 1, got);
    expect_word(got, 32'h0);
  endtask
  task automatic t_pattern_gen();
    alrb_word_t got;
    int n;
    bus_wr(ba(`ALRB_AREA_GEN_BASE + 11'h1), 32'h8, 4'hf, 0);
    txq.delete();
    bus_wr(ba(`ALRB_AREA_GEN_BASE), 32'h1, 4'hf, 2);
    n = 0;
    while (txq.size() < 8 && n < 400) begin
      @(posedge clock_in);
      n++;
    end
    if (n >= 400) hang();
    repeat (20) @(posedge clock_in);
    expect_word(32'(txq.size()), 32'h8);
    foreach (txq[k]) expect_word(txq[k], 32'(k));
    bus_rd(ba(`ALRB_AREA_GEN_BASE + 11'h2), 0, got);
    expect_word(got, 32'h8);
  endtask
  task automatic t_pattern_ver();
    alrb_word_t got;
    bus_wr(ba(`ALRB_AREA_VER_BASE), 32'h1, 4'hf, 0);
    repeat (8) @(posedge clock_in); // enable crosses two-flop stages
    for (int k = 0; k < 5; k++) rx_beat(32'(k));
    rx_tvalid_in <= 1'b0;
    rx_tdata_in <= 32'hffff_fffb;
    bus_rd(ba(`ALRB_AREA_VER_BASE + 11'h2), 0, got);
    expect_word(got, 32'h5);
    bus_rd(ba(`ALRB_AREA_VER_BASE + 11'h3), 0, got);
    expect_word(got, 32'h0);
    rx_beat(32'h9);
    rx_tvalid_in <= 1'b0;
    rx_tdata_in <= 32'hffff_fff6;
    bus_rd(ba(`ALRB_AREA_VER_BASE + 11'h3), 0, got);
    expect_word(got, 32'h1);
  endtask
  task automatic t_second_reset();
    alrb_word_t got;
    rst_n_in <= 1'b0;
    repeat (16) @(posedge clock_in);
    rst_n_in <= 1'b1;
    bus_rd(ba(11'h001), 0, got);
    expect_word(got, `ALRB_RESET_WORD);
  endtask
  initial begin
    repeat (16) @(posedge clock_in);
    rst_n_in <= 1'b1;
    t_area_map();
    t_pattern_gen();
    t_pattern_ver();
    t_second_reset();
    tally_and_finish();
  end
endmodule
